// ==== hdl/tmr_pkg.sv ====
// Purpose: Constants and carrier types of the 16-bit timer control, status and event block.
// Assumes: One register port with a 4-bit offset and 8-bit data.
// Notes:   What this block does is listed below, one line per behaviour.
// What this block does
// - All timer events share one masked interrupt.
// - Every unmasked timer interrupt wakes wait, never halt.
// - Capture enable raises interrupt on capture flags.
// - Compare enable raises interrupt on compare flags.
// - Overflow enable raises interrupt on overflow flag.
// - Writing force B copies level B out.
// - Writing force A copies level A out.
// - Level B drives B pin; pulse modes A.
// - Capture A edge select: 0 falling, 1 rising.
// - Level A drives A pin on A match.
// - A pin enable routes output only.
// - B pin enable routes output only.
// - Single pulse: capture A edge fires pulse.
// - PWM: A sets pulse, B sets period.
// - Clock select: /4, /2, /8 or external.
// - PWM mode suppresses compare flags and interrupts.
// - Capture B edge select: 0 falling, 1 rising.
// - External clock edge select: 0 falling, 1 rising.
// - Capture A flag set; status read then low.
// - Compare A flag set; status read then low.
// - Overflow flag on wrap; counter low clears.
// - Capture B and compare B flags; reserved zero.
// - Single pulse trigger reloads counter and capture.
// - PWM period match reloads counter with FFFCh.

package tmr_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [3:0] OFS_CTRL_B     = 4'h1;
   localparam logic [3:0] OFS_CTRL_A     = 4'h2;
   localparam logic [3:0] OFS_STATUS     = 4'h3;
   localparam logic [3:0] OFS_CAP_A_HIGH = 4'h4;
   localparam logic [3:0] OFS_CAP_A_LOW  = 4'h5;
   localparam logic [3:0] OFS_CMP_A_HIGH = 4'h6;
   localparam logic [3:0] OFS_CMP_A_LOW  = 4'h7;
   localparam logic [3:0] OFS_CNT_HIGH   = 4'h8;
   localparam logic [3:0] OFS_CNT_LOW    = 4'h9;
   localparam logic [3:0] OFS_ALT_HIGH   = 4'ha;
   localparam logic [3:0] OFS_ALT_LOW    = 4'hb;
   localparam logic [3:0] OFS_CAP_B_HIGH = 4'hc;
   localparam logic [3:0] OFS_CAP_B_LOW  = 4'hd;
   localparam logic [3:0] OFS_CMP_B_HIGH = 4'he;
   localparam logic [3:0] OFS_CMP_B_LOW  = 4'hf;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int A_CAP_IE   = 7;
   localparam int A_CMP_IE   = 6;
   localparam int A_OVF_IE   = 5;
   localparam int A_FORCE_B  = 4;
   localparam int A_FORCE_A  = 3;
   localparam int A_LEVEL_B  = 2;
   localparam int A_CAP_EDGE = 1;
   localparam int A_LEVEL_A  = 0;
   localparam int B_PIN_A_EN = 7;
   localparam int B_PIN_B_EN = 6;
   localparam int B_PULSE    = 5;
   localparam int B_PWM      = 4;
   localparam int B_CLK_HI   = 3;
   localparam int B_CLK_LO   = 2;
   localparam int B_CAP_EDGE = 1;
   localparam int B_EXT_EDGE = 0;
   // Flag vector index; the status byte is the vector over three zero bits.
   localparam int F_CAP_A = 4;
   localparam int F_CMP_A = 3;
   localparam int F_OVF   = 2;
   localparam int F_CAP_B = 1;
   localparam int F_CMP_B = 0;

   // ------------------------------------------------------------
   // Reset values, reload values and clock codes
   // ------------------------------------------------------------
   localparam logic [7:0]  CTRL_RESET     = 8'h00;
   localparam logic [15:0] CNT_RELOAD     = 16'hfffc;
   localparam logic [15:0] CNT_MAX        = 16'hffff;
   localparam logic [15:0] CAP_PULSE_LOAD = 16'hfffd;
   localparam logic [15:0] CMP_RESET      = 16'h8000;
   localparam logic [1:0]  CLK_DIV4       = 2'h0;
   localparam logic [1:0]  CLK_DIV2       = 2'h1;
   localparam logic [1:0]  CLK_DIV8       = 2'h2;
   localparam logic [2:0]  PRE_MASK_DIV2  = 3'h1;
   localparam logic [2:0]  PRE_MASK_DIV4  = 3'h3;
   localparam logic [2:0]  PRE_MASK_DIV8  = 3'h7;
   localparam logic        EXT_CLK_FITTED = 1'b1;

   // ------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tmr_bus_req_type;

   typedef struct packed {
      logic cap_a;
      logic cap_b;
      logic ext_clk;
   } tmr_pins_in_type;

endpackage

// ==== hdl/tmr_core.sv ====
// Purpose: 16-bit free-running timer with capture, compare, pulse and PWM modes.
// Assumes: Pins and bus signals are synchronous to ref_clk_i.
// Notes:   Read data appears in the cycle after the read strobe.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module tmr_core (
   // Clock and reset
   input  wire logic                     ref_clk_i,
   input  wire logic                     rstn_i,
   // Register port
   input  wire tmr_pkg::tmr_bus_req_type bus_req_i,
   output logic [7:0]                    bus_rdata_o,
   // Board pins
   input  wire tmr_pkg::tmr_pins_in_type pins_i,
   output logic                          compare_a_out_o,
   output logic                          compare_a_en_o,
   output logic                          compare_b_out_o,
   output logic                          compare_b_en_o,
   // CPU side
   input  wire logic                     cpu_mask_i,
   output logic                          irq_o,
   output logic                          wait_wake_o,
   output logic                          halt_wake_o
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0]  ctrl_a;
   logic [7:0]  ctrl_b;
   logic [15:0] count;
   logic [15:0] next_count;
   logic [15:0] count_inc;
   logic [15:0] cmp_a_val;
   logic [15:0] cmp_b_val;
   logic [15:0] cap_a_val;
   logic [15:0] cap_b_val;
   logic        cmp_a_hold;
   logic        cmp_b_hold;
   logic [2:0]  pre;
   logic        cap_a_prev;
   logic        cap_b_prev;
   logic        ext_prev;
   logic        primed;
   logic [4:0]  flag;
   logic [4:0]  arm;
   logic [4:0]  flag_set;
   logic [4:0]  low_access;
   logic        out_a;
   logic        out_b;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic       wr_a;
   logic       wr_b;
   logic       rd_status;
   logic       pwm_on;
   logic       pulse_on;
   logic       plain_on;
   logic [1:0] clk_sel;
   logic       step;
   logic       cap_a_edge;
   logic       cap_b_edge;
   logic       ext_edge;
   logic       hit_a;
   logic       hit_b;
   logic       ovf_evt;
   logic       pulse_trig;
   logic       cnt_wr;

   assign wr_a      = bus_req_i.wr && (bus_req_i.addr == tmr_pkg::OFS_CTRL_A);
   assign wr_b      = bus_req_i.wr && (bus_req_i.addr == tmr_pkg::OFS_CTRL_B);
   assign rd_status = bus_req_i.rd && (bus_req_i.addr == tmr_pkg::OFS_STATUS);
   assign cnt_wr    = bus_req_i.wr && ((bus_req_i.addr == tmr_pkg::OFS_CNT_LOW) ||
                                       (bus_req_i.addr == tmr_pkg::OFS_ALT_LOW));
   assign pwm_on    = ctrl_b[tmr_pkg::B_PWM];
   assign pulse_on  = ctrl_b[tmr_pkg::B_PULSE] && !pwm_on;
   assign plain_on  = !pwm_on && !pulse_on;
   assign clk_sel   = ctrl_b[tmr_pkg::B_CLK_HI:tmr_pkg::B_CLK_LO];

   // ------------------------------------------------------------
   // Edge detection
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cap_a_prev <= 1'b0;
         cap_b_prev <= 1'b0;
         ext_prev   <= 1'b0;
         primed     <= 1'b0;
      end else begin
         primed     <= 1'b1;
         cap_a_prev <= pins_i.cap_a;
         cap_b_prev <= pins_i.cap_b;
         ext_prev   <= pins_i.ext_clk;
      end
   end

   // An edge is a change of level; the select bit keeps only one direction.
   assign cap_a_edge = primed && (pins_i.cap_a != cap_a_prev) &&
                       (pins_i.cap_a == ctrl_a[tmr_pkg::A_CAP_EDGE]);
   assign cap_b_edge = primed && (pins_i.cap_b != cap_b_prev) &&
                       (pins_i.cap_b == ctrl_b[tmr_pkg::B_CAP_EDGE]);
   assign ext_edge   = primed && (pins_i.ext_clk != ext_prev) &&
                       (pins_i.ext_clk == ctrl_b[tmr_pkg::B_EXT_EDGE]);

   // ------------------------------------------------------------
   // Prescaler
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pre <= 3'h0;
      end else begin
         pre <= pre + 3'h1;
      end
   end

   always_comb begin
      case (clk_sel)
         tmr_pkg::CLK_DIV4: step = ((pre & tmr_pkg::PRE_MASK_DIV4) == tmr_pkg::PRE_MASK_DIV4);
         tmr_pkg::CLK_DIV2: step = ((pre & tmr_pkg::PRE_MASK_DIV2) == tmr_pkg::PRE_MASK_DIV2);
         tmr_pkg::CLK_DIV8: step = (pre == tmr_pkg::PRE_MASK_DIV8);
         default:           step = tmr_pkg::EXT_CLK_FITTED && ext_edge;
      endcase
   end

   // ------------------------------------------------------------
   // Counter and events
   // ------------------------------------------------------------
   assign count_inc  = count + 16'h0001;
   assign ovf_evt    = step && (count == tmr_pkg::CNT_MAX) && (next_count == 16'h0000);
   // A high-byte write holds off matching until the low byte completes the value.
   assign hit_a      = step && (count_inc == cmp_a_val) && !cmp_a_hold;
   assign hit_b      = step && (count_inc == cmp_b_val) && !cmp_b_hold;
   assign pulse_trig = pulse_on && cap_a_edge;

   always_comb begin
      next_count = count;
      if (cnt_wr || pulse_trig) begin
         next_count = tmr_pkg::CNT_RELOAD;
      end else if (pwm_on && hit_b) begin
         next_count = tmr_pkg::CNT_RELOAD;
      end else if (step) begin
         next_count = count_inc;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         count <= tmr_pkg::CNT_RELOAD;
      end else begin
         count <= next_count;
      end
   end

   // ------------------------------------------------------------
   // Captures
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cap_a_val <= 16'h0000;
         cap_b_val <= 16'h0000;
      end else begin
         if (pulse_trig) begin
            cap_a_val <= tmr_pkg::CAP_PULSE_LOAD;
         end else if (plain_on && cap_a_edge) begin
            cap_a_val <= count;
         end
         if (cap_b_edge) begin
            cap_b_val <= count;
         end
      end
   end

   // ------------------------------------------------------------
   // Flags with two-step clearing
   // ------------------------------------------------------------
   // PWM takes capture A's edge away; its period match sets that flag instead.
   assign flag_set[tmr_pkg::F_CAP_A] = (plain_on && cap_a_edge) || pulse_trig ||
                                       (pwm_on && hit_b);
   assign flag_set[tmr_pkg::F_CMP_A] = hit_a && plain_on;
   assign flag_set[tmr_pkg::F_OVF]   = ovf_evt;
   assign flag_set[tmr_pkg::F_CAP_B] = cap_b_edge;
   assign flag_set[tmr_pkg::F_CMP_B] = hit_b && !pwm_on;

   // The alternate counter low byte is left out on purpose so it never clears overflow.
   assign low_access[tmr_pkg::F_CAP_A] = (bus_req_i.rd || bus_req_i.wr) &&
                                         (bus_req_i.addr == tmr_pkg::OFS_CAP_A_LOW);
   assign low_access[tmr_pkg::F_CMP_A] = (bus_req_i.rd || bus_req_i.wr) &&
                                         (bus_req_i.addr == tmr_pkg::OFS_CMP_A_LOW);
   assign low_access[tmr_pkg::F_OVF]   = (bus_req_i.rd || bus_req_i.wr) &&
                                         (bus_req_i.addr == tmr_pkg::OFS_CNT_LOW);
   assign low_access[tmr_pkg::F_CAP_B] = (bus_req_i.rd || bus_req_i.wr) &&
                                         (bus_req_i.addr == tmr_pkg::OFS_CAP_B_LOW);
   assign low_access[tmr_pkg::F_CMP_B] = (bus_req_i.rd || bus_req_i.wr) &&
                                         (bus_req_i.addr == tmr_pkg::OFS_CMP_B_LOW);

   for (genvar i = 0; i < 5; i++) begin : g_flag
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            flag[i] <= 1'b0;
            arm[i]  <= 1'b0;
         end else begin
            // A new event in the clearing cycle wins over the clear.
            if (flag_set[i]) begin
               flag[i] <= 1'b1;
            end else if (arm[i] && low_access[i]) begin
               flag[i] <= 1'b0;
            end
            if (rd_status) begin
               arm[i] <= flag[i];
            end else if (arm[i] && low_access[i]) begin
               arm[i] <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_a     <= tmr_pkg::CTRL_RESET;
         ctrl_b     <= tmr_pkg::CTRL_RESET;
         cmp_a_val  <= tmr_pkg::CMP_RESET;
         cmp_b_val  <= tmr_pkg::CMP_RESET;
         cmp_a_hold <= 1'b0;
         cmp_b_hold <= 1'b0;
      end else if (bus_req_i.wr) begin
         case (bus_req_i.addr)
            tmr_pkg::OFS_CTRL_A: ctrl_a <= bus_req_i.wdata;
            tmr_pkg::OFS_CTRL_B: ctrl_b <= bus_req_i.wdata;
            tmr_pkg::OFS_CMP_A_HIGH: begin
               cmp_a_val[15:8] <= bus_req_i.wdata;
               cmp_a_hold      <= 1'b1;
            end
            tmr_pkg::OFS_CMP_A_LOW: begin
               cmp_a_val[7:0] <= bus_req_i.wdata;
               cmp_a_hold     <= 1'b0;
            end
            tmr_pkg::OFS_CMP_B_HIGH: begin
               cmp_b_val[15:8] <= bus_req_i.wdata;
               cmp_b_hold      <= 1'b1;
            end
            tmr_pkg::OFS_CMP_B_LOW: begin
               cmp_b_val[7:0] <= bus_req_i.wdata;
               cmp_b_hold     <= 1'b0;
            end
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bus_rdata_o <= 8'h00;
      end else if (bus_req_i.rd) begin
         case (bus_req_i.addr)
            tmr_pkg::OFS_CTRL_A:     bus_rdata_o <= ctrl_a;
            tmr_pkg::OFS_CTRL_B:     bus_rdata_o <= ctrl_b;
            tmr_pkg::OFS_STATUS:     bus_rdata_o <= {flag, 3'h0};
            tmr_pkg::OFS_CAP_A_HIGH: bus_rdata_o <= cap_a_val[15:8];
            tmr_pkg::OFS_CAP_A_LOW:  bus_rdata_o <= cap_a_val[7:0];
            tmr_pkg::OFS_CMP_A_HIGH: bus_rdata_o <= cmp_a_val[15:8];
            tmr_pkg::OFS_CMP_A_LOW:  bus_rdata_o <= cmp_a_val[7:0];
            tmr_pkg::OFS_CNT_HIGH:   bus_rdata_o <= count[15:8];
            tmr_pkg::OFS_CNT_LOW:    bus_rdata_o <= count[7:0];
            tmr_pkg::OFS_ALT_HIGH:   bus_rdata_o <= count[15:8];
            tmr_pkg::OFS_ALT_LOW:    bus_rdata_o <= count[7:0];
            tmr_pkg::OFS_CAP_B_HIGH: bus_rdata_o <= cap_b_val[15:8];
            tmr_pkg::OFS_CAP_B_LOW:  bus_rdata_o <= cap_b_val[7:0];
            tmr_pkg::OFS_CMP_B_HIGH: bus_rdata_o <= cmp_b_val[15:8];
            tmr_pkg::OFS_CMP_B_LOW:  bus_rdata_o <= cmp_b_val[7:0];
            default:                 bus_rdata_o <= 8'h00;
         endcase
      end else begin
         bus_rdata_o <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Compare outputs
   // ------------------------------------------------------------
   // The pin enables only gate what reaches the pins; matching runs regardless.
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_a <= 1'b0;
      end else if (wr_a && bus_req_i.wdata[tmr_pkg::A_FORCE_A]) begin
         out_a <= bus_req_i.wdata[tmr_pkg::A_LEVEL_A];
      end else if (!plain_on && (pulse_trig || (pwm_on && hit_b))) begin
         out_a <= ctrl_a[tmr_pkg::A_LEVEL_B];
      end else if (hit_a) begin
         out_a <= ctrl_a[tmr_pkg::A_LEVEL_A];
      end
   end

   // In single pulse mode level B belongs to the pulse, so the B pin holds still.
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_b <= 1'b0;
      end else if (wr_a && bus_req_i.wdata[tmr_pkg::A_FORCE_B]) begin
         out_b <= bus_req_i.wdata[tmr_pkg::A_LEVEL_B];
      end else if (plain_on && hit_b) begin
         out_b <= ctrl_a[tmr_pkg::A_LEVEL_B];
      end
   end

   assign compare_a_out_o = out_a;
   assign compare_b_out_o = out_b;
   assign compare_a_en_o  = ctrl_b[tmr_pkg::B_PIN_A_EN];
   assign compare_b_en_o  = ctrl_b[tmr_pkg::B_PIN_B_EN];

   // ------------------------------------------------------------
   // Interrupt request
   // ------------------------------------------------------------
   logic ev_req;
   assign ev_req = (ctrl_a[tmr_pkg::A_CAP_IE] &&
                    (flag[tmr_pkg::F_CAP_A] || flag[tmr_pkg::F_CAP_B])) ||
                   (ctrl_a[tmr_pkg::A_CMP_IE] &&
                    (flag[tmr_pkg::F_CMP_A] || flag[tmr_pkg::F_CMP_B])) ||
                   (ctrl_a[tmr_pkg::A_OVF_IE] && flag[tmr_pkg::F_OVF]);
   assign irq_o       = ev_req && !cpu_mask_i;
   assign wait_wake_o = irq_o;
   assign halt_wake_o = 1'b0;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   irq_masked_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      cpu_mask_i |-> !irq_o) else $error("interrupt raised while masked");
   wake_follows_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (irq_o == wait_wake_o) && !halt_wake_o) else $error("wake outputs wrong");
   cap_irq_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      ctrl_a[tmr_pkg::A_CAP_IE] && !wr_a && cap_b_edge |=> cpu_mask_i || irq_o)
      else $error("capture interrupt missing");
   ovf_wrap_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      ovf_evt && !cnt_wr && !pulse_trig && !(pwm_on && hit_b)
      |=> (count == 16'h0000) && flag[tmr_pkg::F_OVF]) else $error("wrap wrong");
   pwm_noflag_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      $past(pwm_on) |-> !$rose(flag[tmr_pkg::F_CMP_A]) && !$rose(flag[tmr_pkg::F_CMP_B]))
      else $error("compare flag set in PWM");
   pwm_reload_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      pwm_on && hit_b |=> (count == tmr_pkg::CNT_RELOAD) && flag[tmr_pkg::F_CAP_A]
      && (out_a == $past(ctrl_a[2]) || $past(wr_a))) else $error("PWM period wrong");
   pulse_trig_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      pulse_trig |=> (count == tmr_pkg::CNT_RELOAD) &&
      (cap_a_val == tmr_pkg::CAP_PULSE_LOAD)) else $error("pulse trigger wrong");
   force_b_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      wr_a && bus_req_i.wdata[4] |=> out_b == $past(bus_req_i.wdata[2]))
      else $error("force B not applied");
   clear_seq_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      rd_status && flag[tmr_pkg::F_CMP_A] ##1 !low_access[tmr_pkg::F_CMP_A] ##1
      low_access[tmr_pkg::F_CMP_A] && !flag_set[tmr_pkg::F_CMP_A] |=> !flag[tmr_pkg::F_CMP_A])
      else $error("clear failed");
   div2_step_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      clk_sel == tmr_pkg::CLK_DIV2 && step ##1 clk_sel == tmr_pkg::CLK_DIV2 |-> !step)
      else $error("divide by two wrong");

endmodule

`default_nettype wire

// ==== tb/test_timer16_control_status_irq.sv ====
// Purpose: Self-checking bench for the timer control, status and event block.
// Assumes: Register reads return data in the cycle after the read strobe.
// Notes:   Counter starts at FFFCh, so an overflow comes within a few dozen cycles.
`timescale 1ns/100ps
`default_nettype none

module test_timer16_control_status_irq;
   logic                     ref_clk_i = 1'b0;
   logic                     rstn_i    = 1'b0;
   tmr_pkg::tmr_bus_req_type bus_req   = '0;
   tmr_pkg::tmr_pins_in_type pins      = '0;
   logic                     cpu_mask  = 1'b1;
   logic [7:0]               rdata;
   logic                     out_a, en_a, out_b, en_b, irq, wwake, hwake;
   int                       n_mismatch = 0;
   int                       tests_run  = 0;
   int                       cycles     = 0;

   tmr_core i_tmr_core (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .bus_req_i(bus_req),
      .bus_rdata_o(rdata), .pins_i(pins), .compare_a_out_o(out_a), .compare_a_en_o(en_a),
      .compare_b_out_o(out_b), .compare_b_en_o(en_b), .cpu_mask_i(cpu_mask),
      .irq_o(irq), .wait_wake_o(wwake), .halt_wake_o(hwake));

   // ------------------------------------------------------------
   // Clock, reset and hang guard
   // ------------------------------------------------------------
   initial begin
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   // The whole run needs a few hundred cycles; a hang is cut short well beyond that.
   always @(posedge ref_clk_i) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         n_mismatch = n_mismatch + 1;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Shared bus and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      bus_req <= {a, d, 1'b1, 1'b0};
      @(posedge ref_clk_i);
      bus_req <= '0;
   endtask

   // Read data is sampled after the edge that ends the strobe, the only cycle it stands.
   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      bus_req <= {a, 8'h00, 1'b0, 1'b1};
      @(posedge ref_clk_i);
      bus_req <= '0;
      #1 d = rdata;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] v;
      reg_rd(tmr_pkg::OFS_CTRL_A, v); chk("control_a", v, 8'h00);
      reg_rd(tmr_pkg::OFS_CTRL_B, v); chk("control_b", v, 8'h00);
      reg_rd(tmr_pkg::OFS_STATUS, v); chk("status", v, 8'h00);
      chk("halt wake", {7'h00, hwake}, 8'h00);
      $display("Test reset done");
   endtask

   task automatic t_overflow();
      logic [7:0] v;
      reg_wr(tmr_pkg::OFS_CTRL_A, 8'h20);
      wait_cyc(40);
      @(posedge ref_clk_i);
      cpu_mask <= 1'b0;
      wait_cyc(1);
      chk("irq overflow", {7'h00, irq}, 8'h01);
      chk("wait wake", {7'h00, wwake}, 8'h01);
      @(posedge ref_clk_i);
      cpu_mask <= 1'b1;
      wait_cyc(1);
      chk("irq masked", {7'h00, irq}, 8'h00);
      reg_rd(tmr_pkg::OFS_STATUS, v); chk("status ovf", v, 8'h20);
      reg_rd(tmr_pkg::OFS_ALT_LOW, v);
      reg_rd(tmr_pkg::OFS_STATUS, v); chk("ovf after alt", v, 8'h20);
      reg_rd(tmr_pkg::OFS_CNT_LOW, v);
      reg_rd(tmr_pkg::OFS_STATUS, v); chk("ovf cleared", v, 8'h00);
      $display("Test overflow done");
   endtask

   task automatic t_force();
      reg_wr(tmr_pkg::OFS_CTRL_B, 8'hc0);
      reg_wr(tmr_pkg::OFS_CTRL_A, 8'h09);
      reg_wr(tmr_pkg::OFS_CTRL_A, 8'h14);
      reg_wr(tmr_pkg::OFS_CTRL_A, 8'h00);
      wait_cyc(2);
      chk("pin a enable", {7'h00, en_a}, 8'h01);
      chk("pin b enable", {7'h00, en_b}, 8'h01);
      chk("forced out a", {7'h00, out_a}, 8'h01);
      chk("forced out b", {7'h00, out_b}, 8'h01);
      $display("Test force done");
   endtask

   task automatic t_capture_b();
      logic [7:0] v;
      reg_wr(tmr_pkg::OFS_CTRL_B, 8'h02);
      reg_wr(tmr_pkg::OFS_CTRL_A, 8'h80);
      pins.cap_b <= 1'b1;
      wait_cyc(3);
      @(posedge ref_clk_i);
      cpu_mask <= 1'b0;
      wait_cyc(1);
      chk("irq capture", {7'h00, irq}, 8'h01);
      reg_rd(tmr_pkg::OFS_STATUS, v); chk("status cap b", v, 8'h10);
      reg_rd(tmr_pkg::OFS_CAP_B_LOW, v);
      reg_rd(tmr_pkg::OFS_STATUS, v); chk("cap b cleared", v, 8'h00);
      $display("Test capture b done");
   endtask

   task automatic t_compare_a();
      logic [7:0] v;
      reg_wr(tmr_pkg::OFS_CMP_A_HIGH, 8'h00);
      reg_wr(tmr_pkg::OFS_CMP_A_LOW, 8'h02);
      reg_wr(tmr_pkg::OFS_CTRL_A, 8'h08);
      reg_wr(tmr_pkg::OFS_CTRL_A, 8'h41);
      reg_wr(tmr_pkg::OFS_CNT_LOW, 8'h00);
      wait_cyc(40);
      chk("match out a", {7'h00, out_a}, 8'h01);
      chk("irq compare", {7'h00, irq}, 8'h01);
      reg_rd(tmr_pkg::OFS_STATUS, v);
      chk("status cmp a", v, 8'h60);
      reg_rd(tmr_pkg::OFS_CMP_A_LOW, v);
      chk("cmp a low", v, 8'h02);
      reg_rd(tmr_pkg::OFS_STATUS, v);
      chk("cmp a cleared", v, 8'h20);
      reg_rd(tmr_pkg::OFS_CNT_LOW, v);
      $display("Test compare a done");
   endtask

   // Compare A high is left unpaired at the end so no match leaks into the next test.
   task automatic t_pwm();
      logic [7:0] v;
      reg_wr(tmr_pkg::OFS_CMP_A_LOW, 8'h01);
      reg_wr(tmr_pkg::OFS_CMP_B_HIGH, 8'h00);
      reg_wr(tmr_pkg::OFS_CMP_B_LOW, 8'h03);
      reg_wr(tmr_pkg::OFS_CTRL_A, 8'h84);
      reg_wr(tmr_pkg::OFS_CTRL_B, 8'h94);
      reg_wr(tmr_pkg::OFS_CNT_LOW, 8'h00);
      wait_cyc(40);
      chk("irq pwm period", {7'h00, irq}, 8'h01);
      reg_rd(tmr_pkg::OFS_STATUS, v);
      chk("status pwm", v, 8'ha0);
      reg_wr(tmr_pkg::OFS_CMP_A_HIGH, 8'h00);
      reg_wr(tmr_pkg::OFS_CTRL_B, 8'h00);
      reg_rd(tmr_pkg::OFS_STATUS, v);
      reg_rd(tmr_pkg::OFS_CAP_A_LOW, v);
      reg_rd(tmr_pkg::OFS_STATUS, v);
      chk("cap a cleared", v & 8'he0, 8'h20);
      $display("Test pwm done");
   endtask

   task automatic t_pulse();
      logic [7:0] v;
      reg_wr(tmr_pkg::OFS_CTRL_A, 8'h03);
      reg_wr(tmr_pkg::OFS_CTRL_B, 8'ha0);
      pins.cap_a <= 1'b1;
      wait_cyc(1);
      chk("pulse start", {7'h00, out_a}, 8'h00);
      reg_wr(tmr_pkg::OFS_CMP_A_LOW, 8'h01);
      wait_cyc(40);
      chk("pulse end", {7'h00, out_a}, 8'h01);
      reg_rd(tmr_pkg::OFS_CAP_A_HIGH, v);
      chk("pulse capture hi", v, 8'hff);
      reg_rd(tmr_pkg::OFS_CAP_A_LOW, v);
      chk("pulse capture lo", v, 8'hfd);
      reg_rd(tmr_pkg::OFS_STATUS, v);
      chk("status pulse", v & 8'hc0, 8'h80);
      $display("Test pulse done");
   endtask

   initial begin
      repeat (16) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      t_reset();
      t_overflow();
      t_force();
      t_capture_b();
      t_compare_a();
      t_pwm();
      t_pulse();
      finish_test();
   end
endmodule

`default_nettype wire
